// File: include/spd_pkg.sv
// Package with shared constants and types for the serial to parallel output driver.
package spd_pkg;
    // Geometry of the driver.
    localparam int unsigned SPD_STAGES      = 32;
    // Host timing limits: shift clock rate in kHz, times in ns.
    localparam int unsigned SPD_CLK_MAX_KHZ    = 8000;
    localparam int unsigned SPD_WIDTH_NS       = 62;
    localparam int unsigned SPD_LATCH_DLY_NS   = 50;
    localparam int unsigned SPD_LATCH_WID_NS   = 50;
    localparam int unsigned SPD_LATCH_SU_NS    = 50;
    // Host system clock period in ns.
    localparam int unsigned SPD_SYS_NS      = 50;
    // Least times round up to whole host cycles.
    localparam int unsigned SPD_WIDTH_CYC   = (SPD_WIDTH_NS + SPD_SYS_NS - 1) / SPD_SYS_NS;
    localparam int unsigned SPD_LATCH_DLY_CYC = (SPD_LATCH_DLY_NS + SPD_SYS_NS - 1) / SPD_SYS_NS;
    localparam int unsigned SPD_LATCH_WID_CYC = (SPD_LATCH_WID_NS + SPD_SYS_NS - 1) / SPD_SYS_NS;
    localparam int unsigned SPD_LATCH_SU_CYC  = (SPD_LATCH_SU_NS + SPD_SYS_NS - 1) / SPD_SYS_NS;
    // Host sequencer states.
    typedef enum logic [2:0] {
        SPD_IDLE,
        SPD_LOW,
        SPD_HIGH,
        SPD_LATCH_WAIT,
        SPD_LATCH_ON,
        SPD_LATCH_OFF
    } spd_state_t;
endpackage

// File: include/spd_if.sv
// Interface joining the host controller to the output driver.
`timescale 1ns/10ps
interface spd_if;
    logic shift_clk;
    logic serial_in;
    logic serial_out;
    logic latch_transparent;
    logic output_blank_n;
    logic output_polarity_n;
    logic [31:0] drive_output;
    modport device (
        input  shift_clk,
        input  serial_in,
        output serial_out,
        input  latch_transparent,
        input  output_blank_n,
        input  output_polarity_n,
        output drive_output
    );
    modport host (
        output shift_clk,
        output serial_in,
        input  serial_out,
        output latch_transparent,
        output output_blank_n,
        output output_polarity_n,
        input  drive_output
    );
endinterface

// File: hdl/spd_fifo.sv
// Small valid/ready FIFO that buffers frames on the host side.
`timescale 1ns/10ps
module spd_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // Filling side.
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Draining side.
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // Depth is a power of two, so the full count is the top bit alone.
    localparam logic [AW:0] DEPTH_CNT = {1'b1, {AW{1'b0}}};

    // Elaboration check: the pointers wrap only for a power of two depth.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_depth_check
        $error("spd_fifo needs a power of two depth of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } spd_fifo_st_t;

    spd_fifo_st_t st;
    spd_fifo_st_t next_st;
    logic         push;
    logic         pop;

    // Handshake flags come straight from the count, so full and empty are exact.
    assign in_ready_o  = (st.cnt != DEPTH_CNT);
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o  = mem[st.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer and count update.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage has no reset; only words below the count are ever read.
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[st.wr] <= in_data_i;
        end
    end
endmodule

// File: hdl/spd_driver.sv
// Device end: 32 stage shift register, transparent latches and blank/polarity outputs.
//
// Behaviour
// - Thirty-two stages, latches and outputs.
// - Shift once per rising shift clock.
// - Output one comes from stage one.
// - Serial out shows the last stage.
// - Latch, blank, polarity never affect shifting.
// - Latch high: latches follow stages continuously.
// - Latch low: latches hold, shifting continues.
// - Blank forces outputs; polarity inverts or passes.
// - Outputs are always driven high or low.
// - Host sets data before rising edge.
// - Host keeps shift clock within 8 MHz.
// - Host keeps clock phases at least 62 ns.
// - Host waits 50 ns before latch high.
// - Host drops latch 50 ns before edge.
// - Serial out chains into next device.
`timescale 1ns/10ps
module spd_driver
    import spd_pkg::*;
#(
    parameter int unsigned STAGES = SPD_STAGES
) (
    // Link side.
    spd_if.device link
);
    // Elaboration check: the link carries a fixed number of outputs.
    if (STAGES != SPD_STAGES) begin : g_stage_check
        $error("spd_driver carries exactly 32 stages on its link");
    end

    typedef struct packed {
        logic [STAGES-1:0] shreg;
    } spd_drv_st_t;

    spd_drv_st_t       st;
    spd_drv_st_t       next_st;
    logic [STAGES-1:0] latch_q;
    logic [STAGES-1:0] driven;

    // The driver has no reset input, so the stages power up unknown until loaded.
    always_comb begin
        next_st       = st;
        next_st.shreg = {st.shreg[STAGES-2:0], link.serial_in};
    end

    // Only the shift clock and data reach this process.
    always_ff @(posedge link.shift_clk) begin
        st <= next_st;
    end

    // Level sensitive latches; a flip-flop would lose the flow-through while transparent.
    always_latch begin
        if (link.latch_transparent) begin
            latch_q <= st.shreg;
        end
    end

    // Blanking takes priority; with polarity low every output is forced high.
    assign driven = !link.output_blank_n ? {STAGES{!link.output_polarity_n}}
                  : (link.output_polarity_n ? latch_q : ~latch_q);

    assign link.drive_output = driven;
    assign link.serial_out   = st.shreg[STAGES-1];
endmodule

// File: hdl/spd_host.sv
// Host end: buffers 32 bit frames, shifts them out and pulses the latch control.
`timescale 1ns/10ps
module spd_host
    import spd_pkg::*;
#(
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Frame input.
    input  wire logic        frame_valid_i,
    output logic             frame_ready_o,
    input  wire logic [31:0] frame_data_i,
    // Output mode controls, passed to the link.
    input  wire logic        blank_n_i,
    input  wire logic        polarity_n_i,
    // Status.
    output logic             busy_o,
    // Link side.
    spd_if.host              link
);
    localparam logic [5:0] HALF_CYC  = 6'(SPD_WIDTH_CYC);
    localparam logic [5:0] DLY_CYC   = 6'(SPD_LATCH_DLY_CYC);
    localparam logic [5:0] WID_CYC   = 6'(SPD_LATCH_WID_CYC);
    localparam logic [5:0] SU_CYC    = 6'(SPD_LATCH_SU_CYC);
    localparam logic [5:0] LAST_BIT  = 6'(SPD_STAGES - 1);

    // Elaboration check: the divided shift clock must not exceed its maximum rate.
    if (1000000 / (2 * SPD_WIDTH_CYC * SPD_SYS_NS) > SPD_CLK_MAX_KHZ) begin : g_rate_check
        $error("spd_host shift clock would exceed its maximum rate");
    end

    typedef struct packed {
        spd_state_t  state;
        logic [31:0] frame;
        logic [5:0]  bitn;
        logic [5:0]  cnt;
        logic        sclk;
        logic        sdata;
        logic        latch;
        logic        blank_n;
        logic        polar_n;
    } spd_host_st_t;

    spd_host_st_t st;
    spd_host_st_t next_st;
    logic         fifo_valid;
    logic         fifo_pop;
    logic [31:0]  fifo_data;

    // The FIFO stalls the source once eight frames wait.
    spd_fifo #(.WIDTH(32), .DEPTH(DEPTH)) spd_fifo_inst (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (frame_valid_i),
        .in_ready_o  (frame_ready_o),
        .in_data_i   (frame_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_data)
    );

    assign fifo_pop = (st.state == SPD_IDLE) && fifo_valid;

    // Sequencer: last stage is shifted first so bit 0 lands in stage one.
    always_comb begin
        next_st         = st;
        next_st.blank_n = blank_n_i;
        next_st.polar_n = polarity_n_i;
        if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
        end
        case (st.state)
            SPD_IDLE: begin
                if (fifo_valid) begin
                    next_st.frame = fifo_data;
                    next_st.bitn  = LAST_BIT;
                    next_st.sdata = fifo_data[LAST_BIT[4:0]];
                    next_st.cnt   = HALF_CYC - 1'b1;
                    next_st.state = SPD_LOW;
                end
            end
            SPD_LOW: begin
                if (st.cnt == '0) begin
                    next_st.sclk  = 1'b1;
                    next_st.cnt   = HALF_CYC - 1'b1;
                    next_st.state = SPD_HIGH;
                end
            end
            SPD_HIGH: begin
                if (st.cnt == '0) begin
                    next_st.sclk = 1'b0;
                    if (st.bitn == '0) begin
                        next_st.cnt   = DLY_CYC - 1'b1;
                        next_st.state = SPD_LATCH_WAIT;
                    end else begin
                        next_st.bitn  = st.bitn - 1'b1;
                        next_st.sdata = st.frame[5'(st.bitn - 1'b1)];
                        next_st.cnt   = HALF_CYC - 1'b1;
                        next_st.state = SPD_LOW;
                    end
                end
            end
            SPD_LATCH_WAIT: begin
                if (st.cnt == '0) begin
                    next_st.latch = 1'b1;
                    next_st.cnt   = WID_CYC - 1'b1;
                    next_st.state = SPD_LATCH_ON;
                end
            end
            SPD_LATCH_ON: begin
                if (st.cnt == '0) begin
                    next_st.latch = 1'b0;
                    next_st.cnt   = SU_CYC - 1'b1;
                    next_st.state = SPD_LATCH_OFF;
                end
            end
            SPD_LATCH_OFF: begin
                if (st.cnt == '0) begin
                    next_st.state = SPD_IDLE;
                end
            end
            default: begin
                next_st.state = SPD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '{state: SPD_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // Link pins come from flip-flops so they carry no glitches.
    assign link.shift_clk         = st.sclk;
    assign link.serial_in         = st.sdata;
    assign link.latch_transparent = st.latch;
    assign link.output_blank_n    = st.blank_n;
    assign link.output_polarity_n = st.polar_n;
    assign busy_o                 = (st.state != SPD_IDLE);
endmodule

// File: tb/spd_checker.sv
// Checker watching the link between the host end and the output driver.
`timescale 1ns/10ps
module spd_checker (
    // Host clock and reset.
    input wire logic        clk_i,
    input wire logic        rstn_i,
    // Link signals.
    input wire logic        shift_clk,
    input wire logic        serial_in,
    input wire logic        serial_out,
    input wire logic        latch_transparent,
    input wire logic        output_blank_n,
    input wire logic        output_polarity_n,
    input wire logic [31:0] drive_output
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [31:0] stg;
    logic [31:0] lat;
    logic [5:0]  cnt;
    logic        lok;
    logic        full;
    // The driver has no reset, so the shadows only count once fully loaded.
    assign full = (cnt == 6'h20);
    // Shadow stages and latches, sampled on the host clock.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stg <= 32'h0000_0000;
            lat <= 32'h0000_0000;
            cnt <= 6'h0;
            lok <= 1'b0;
        end else begin
            if ($rose(shift_clk)) begin
                stg <= {stg[30:0], serial_in};
                cnt <= full ? cnt : cnt + 6'h1;
            end
            if (latch_transparent && full) begin
                lat <= stg;
                lok <= 1'b1;
            end
        end
    end
    property p_all_high;
        !output_blank_n && !output_polarity_n |-> drive_output == 32'hFFFF_FFFF;
    endproperty
    property p_all_low;
        !output_blank_n && output_polarity_n |-> drive_output == 32'h0000_0000;
    endproperty
    property p_last;
        full && !$rose(shift_clk) |-> serial_out == stg[31];
    endproperty
    property p_advance;
        $rose(shift_clk) && full |=> serial_out == $past(stg[30]);
    endproperty
    property p_follow;
        latch_transparent && output_blank_n && output_polarity_n && full
            && !$rose(shift_clk) |-> drive_output == stg;
    endproperty
    property p_hold;
        lok && !latch_transparent && $stable({output_blank_n, output_polarity_n})
            |-> $stable(drive_output);
    endproperty
    property p_invert;
        lok && output_blank_n && !output_polarity_n && !latch_transparent
            |-> drive_output == ~lat;
    endproperty
    property p_pass;
        lok && output_blank_n && output_polarity_n && !latch_transparent
            |-> drive_output == lat;
    endproperty
    // Host timing on the link, counted in whole host clock cycles.
    property p_phase;
        $changed(shift_clk) |=> $stable(shift_clk);
    endproperty
    property p_data_setup;
        $rose(shift_clk) |-> $stable(serial_in);
    endproperty
    property p_latch_delay;
        $rose(latch_transparent) |-> !shift_clk && !$past(shift_clk);
    endproperty
    property p_latch_setup;
        $rose(shift_clk) |-> !latch_transparent && !$past(latch_transparent);
    endproperty
    a_all_high: assert property (p_all_high) else $error("outputs not all high");
    a_all_low: assert property (p_all_low) else $error("outputs not all low");
    a_last: assert property (p_last) else $error("serial out wrong");
    a_advance: assert property (p_advance) else $error("shift wrong");
    a_follow: assert property (p_follow) else $error("latch not transparent");
    a_hold: assert property (p_hold) else $error("latched outputs moved");
    a_invert: assert property (p_invert) else $error("inverted outputs wrong");
    a_pass: assert property (p_pass) else $error("passed outputs wrong");
    a_phase: assert property (p_phase) else $error("shift clock phase too short");
    a_data_setup: assert property (p_data_setup) else $error("data moved at clock rise");
    a_latch_delay: assert property (p_latch_delay) else $error("latch raised early");
    a_latch_setup: assert property (p_latch_setup) else $error("latch dropped late");
    c_latch: cover property (latch_transparent && full);
    c_invert: cover property (lok && output_blank_n && !output_polarity_n);
    c_blank: cover property (!output_blank_n && output_polarity_n);
endmodule

// File: tb/test_serial_to_parallel_output_driver.sv
// Testbench joining the host end to the output driver and checking the outputs.
`timescale 1ns/10ps
module test_serial_to_parallel_output_driver;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        valid = 1'b0;
    logic        ready;
    logic [31:0] data = 32'h0000_0000;
    logic        blank_n = 1'b0;
    logic        polarity_n = 1'b0;
    logic        busy;
    logic [31:0] exp;
    int          err_count = 0;
    int          tests_run = 0;
    spd_if link ();
    spd_host #(.DEPTH(8)) spd_host_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .frame_valid_i(valid), .frame_ready_o(ready), .frame_data_i(data),
        .blank_n_i(blank_n), .polarity_n_i(polarity_n), .busy_o(busy), .link(link));
    spd_driver #(.STAGES(32)) spd_driver_inst (.link(link));
    spd_checker spd_checker_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .shift_clk(link.shift_clk), .serial_in(link.serial_in),
        .serial_out(link.serial_out), .latch_transparent(link.latch_transparent),
        .output_blank_n(link.output_blank_n), .output_polarity_n(link.output_polarity_n),
        .drive_output(link.drive_output));
    // Host clock, 50 ns period.
    always #25 clk_i = ~clk_i;
    // Prints the verdict and ends the run.
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Compares one value and counts it.
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // Offers one frame and holds it until taken; a stuck handshake ends the run.
    task automatic push(input logic [31:0] d);
        int n;
        @(negedge clk_i);
        valid = 1'b1;
        data = d;
        n = 0;
        while (ready !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 400) begin
            err_count++;
            conclude();
        end else begin
            @(negedge clk_i);
            valid = 1'b0;
        end
    endtask
    // Waits, bounded, for the outputs to show a value, then compares.
    task automatic wait_out(input logic [31:0] want);
        int n;
        n = 0;
        while (link.drive_output !== want && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        check(link.drive_output, want);
        // A wait that used up its bound has already counted as a mismatch.
        if (n == 3000) begin
            conclude();
        end
    endtask
    // Main sequence.
    initial begin
        repeat (16) @(negedge clk_i);
        check(link.drive_output, 32'hFFFF_FFFF);
        rstn_i = 1'b1;
        blank_n = 1'b1;
        polarity_n = 1'b1;
        push(32'hA5C3_0F01);
        wait_out(32'hA5C3_0F01);
        check({31'h0, link.serial_out}, 32'h0000_0001);
        // A new frame shifts in while the old one stays on the outputs.
        push(32'h3C5A_96E2);
        repeat (60) @(negedge clk_i);
        check(link.drive_output, 32'hA5C3_0F01);
        check({31'h0, busy}, 32'h0000_0001);
        // Blanking in mid-load forces the outputs but must not disturb the shifting.
        blank_n = 1'b0;
        polarity_n = 1'b0;
        repeat (3) @(negedge clk_i);
        check(link.drive_output, 32'hFFFF_FFFF);
        blank_n = 1'b1;
        polarity_n = 1'b1;
        wait_out(32'h3C5A_96E2);
        // Every blank and polarity combination.
        for (int m = 0; m < 4; m++) begin
            @(negedge clk_i);
            blank_n = m[1];
            polarity_n = m[0];
            repeat (3) @(negedge clk_i);
            exp = m[1] ? (m[0] ? 32'h3C5A_96E2 : ~32'h3C5A_96E2) : {32{~m[0]}};
            check(link.drive_output, exp);
        end
        // Fill the buffer until it refuses, then drain it.
        for (int i = 1; i < 10; i++) begin
            push({8{i[3:0]}});
        end
        check({31'h0, ready}, 32'h0000_0000);
        check(link.drive_output, 32'h3C5A_96E2);
        push(32'hAAAA_AAAA);
        wait_out(32'hAAAA_AAAA);
        conclude();
    end
endmodule
